// file: design/audio_channel_state_machine.v
// Purpose: one audio channel sequencer with period/length counters
// Assumes: AXI4-Lite registers, DMA handshake as word/restart requests
// Notes:   sequencer advances on a 3.58 MHz enable pulse from a divider
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.

`include "audio_chan_map.vh"
`default_nettype none

module audio_channel_state_machine #(
   parameter DIV = `SYS_DIV
) (
   // Clock and reset
   input  wire        clk,
   input  wire        rst_b,
   // AXI4-Lite write address
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   // AXI4-Lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   // AXI4-Lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read address
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   // AXI4-Lite read data
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // DMA controller side
   output reg         word_fetch_request,
   output reg         pointer_restart_request,
   input  wire        dma_word_valid,
   input  wire [15:0] dma_word,
   // Interrupt circuitry
   input  wire        chan_irq_pending,
   output reg         chan_irq_request,
   // Attach data from the previous channel
   input  wire [15:0] prev_data,
   input  wire        prev_volume_load,
   input  wire        prev_period_load,
   // Converter and attach outputs
   output reg  [7:0]  dac_sample,
   output reg  [6:0]  volume,
   output reg  [15:0] next_chan_data,
   output reg         next_chan_volume_load,
   output reg         next_chan_period_load,
   output reg  [2:0]  state_bits
);

   reg        rst_s1;
   reg        rst_s2;
   reg [7:0]  div_cnt;
   reg        tick;
   reg        chan_dma_enable;
   reg        attach_volume;
   reg        attach_period;
   reg [15:0] period_value_reg;
   reg [15:0] length_backup;
   reg [15:0] period_cnt;
   reg [15:0] length_cnt;
   reg [15:0] hold_latch;
   reg [15:0] out_buf;
   reg        data_written;
   reg        irq_term_prepared;
   reg        penhi;
   reg        aw_got;
   reg        w_got;
   reg [3:0]  aw_addr;
   reg [31:0] w_data;
   reg [3:0]  w_strb;
   reg [2:0]  next_state;
   reg        restart_due;
   localparam [31:0] DIV_W = DIV;

   wire perfin = (period_cnt == 16'h0001);
   wire lenfin = (length_cnt == 16'h0001);
   // requests without attach-period or with attach-volume
   wire napnav = (~attach_volume & ~attach_period) | attach_volume;
   wire hi_to_lo = tick && state_bits == `ST_HIGH && perfin;
   wire lo_to_hi = tick && state_bits == `ST_LOW && perfin;
   // attach-period asks on the 010 to 011 edge; on 011 to 010 only with attach-volume too
   wire req_on_edge = (lo_to_hi & napnav) | (hi_to_lo & attach_period);
   wire wr_fire = aw_got && w_got && !s_axi_bvalid;
   wire data_wr = wr_fire && aw_addr == `REG_DATA;
   // both write and DMA arrival load the holding latch
   wire word_in = data_wr | (dma_word_valid & chan_dma_enable);
   wire [15:0] word_val = data_wr ? w_data[15:0] : dma_word;
   // Pending seen when a word starts means the CPU fell behind
   wire irq_late = chan_irq_pending && !chan_dma_enable;
   wire len_wrap = dma_word_valid && chan_dma_enable && lenfin;
   wire raise_fetch = tick && (
      (state_bits == `ST_IDLE && next_state == `ST_DMA_FIRST) ||
      ((state_bits == `ST_DMA_FIRST || state_bits == `ST_DMA_DROP) &&
       data_written) || (req_on_edge && chan_dma_enable));

   // Reset release through two flops
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1 <= 1'b0;
         rst_s2 <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_s2 <= rst_s1;
      end
   end

   // 3.58 MHz enable pulse from the 200 MHz clock
   always @(posedge clk or negedge rst_s2) begin
      if (!rst_s2) begin
         div_cnt <= 8'h00;
         tick    <= 1'b0;
      end else if (div_cnt == DIV_W[7:0] - 8'h01) begin
         div_cnt <= 8'h00;
         tick    <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 8'h01;
         tick    <= 1'b0;
      end
   end

   // Sequencer next state
   always @* begin
      next_state = state_bits;
      case (state_bits)
         `ST_IDLE: begin
            if (chan_dma_enable)
               next_state = `ST_DMA_FIRST;
            // processor write starts main loop at once
            else if (data_written)
               next_state = `ST_HIGH;
         end
         `ST_DMA_FIRST: begin
            if (!chan_dma_enable)
               next_state = `ST_IDLE;
            else if (data_written)
               next_state = `ST_DMA_DROP;
         end
         `ST_DMA_DROP: begin
            if (!chan_dma_enable)
               next_state = `ST_IDLE;
            else if (data_written)
               next_state = `ST_HIGH;
         end
         `ST_HIGH: begin
            if (perfin)
               next_state = `ST_LOW;
         end
         `ST_LOW: begin
            if (perfin) begin
               // late clear in CPU mode drops back to idle
               // loop ends when DMA enable is low and an interrupt is still pending
               if (irq_late || (!chan_dma_enable && !data_written &&
                   chan_irq_pending))
                  next_state = `ST_IDLE;
               else
                  next_state = `ST_HIGH;
            end
         end
         // unused codes go straight to idle
         default: next_state = `ST_IDLE;
      endcase
   end

   // Sequencer, counters and buffers
   always @(posedge clk or negedge rst_s2) begin
      if (!rst_s2) begin
         state_bits              <= `ST_IDLE;
         period_cnt              <= `PERIOD_RESET;
         length_cnt              <= `LENGTH_RESET;
         hold_latch              <= 16'h0000;
         out_buf                 <= 16'h0000;
         data_written            <= 1'b0;
         irq_term_prepared       <= 1'b0;
         chan_irq_request        <= 1'b0;
         word_fetch_request      <= 1'b0;
         pointer_restart_request <= 1'b0;
         restart_due             <= 1'b0;
         penhi                   <= 1'b0;
         dac_sample              <= 8'h00;
         next_chan_data          <= 16'h0000;
         next_chan_volume_load   <= 1'b0;
         next_chan_period_load   <= 1'b0;
      end else begin
         next_chan_volume_load <= 1'b0;
         next_chan_period_load <= 1'b0;
         chan_irq_request      <= 1'b0;
         // Requests are levels held until the DMA word answers
         if (dma_word_valid) begin
            word_fetch_request      <= 1'b0;
            pointer_restart_request <= 1'b0;
         end
         if (word_in) begin
            hold_latch   <= word_val;
            data_written <= 1'b1;
         end
         if (dma_word_valid && chan_dma_enable) begin
            // length counts down per word, reloads at one
            if (lenfin) begin
               length_cnt              <= length_backup;
               // block-end irq waits for the last word's output
               irq_term_prepared       <= 1'b1;
            end else
               length_cnt <= length_cnt - 16'h0001;
         end
         // restart request rides with the next word request
         if (raise_fetch) begin
            word_fetch_request      <= 1'b1;
            pointer_restart_request <= restart_due | len_wrap;
            restart_due             <= 1'b0;
         end else if (len_wrap)
            restart_due <= 1'b1;
         if (tick) begin
            state_bits <= next_state;
            if ((state_bits == `ST_DMA_FIRST ||
                 state_bits == `ST_DMA_DROP) && data_written) begin
               data_written       <= word_in;
            end
            if (next_state == `ST_HIGH && state_bits != `ST_LOW &&
                state_bits != `ST_HIGH) begin
               out_buf      <= hold_latch;
               data_written <= word_in;
               period_cnt   <= period_value_reg;
               // CPU mode asks for a word as it starts
               if (!chan_dma_enable && napnav)
                  chan_irq_request <= 1'b1;
            end
            if (state_bits == `ST_HIGH || state_bits == `ST_LOW) begin
               // count to one, then reload from period_value_reg
               if (perfin)
                  period_cnt <= period_value_reg;
               else
                  period_cnt <= period_cnt - 16'h0001;
            end
            // buffer refills only when a new word waits
            if (lo_to_hi && data_written) begin
               out_buf      <= hold_latch;
               data_written <= word_in;
            end
            // word done, ask for the next
            // prepared term fires after 011 to 010
            if (lo_to_hi && napnav) begin
               chan_irq_request  <= !chan_dma_enable | irq_term_prepared;
               // A wrap in the same cycle keeps the term armed
               irq_term_prepared <= len_wrap;
            end
            penhi <= (next_state == `ST_HIGH);
            // attach routes words to the next channel
            if (hi_to_lo && attach_period) begin
               next_chan_data        <= out_buf;
               next_chan_period_load <= 1'b1;
            end
            if (lo_to_hi && attach_volume) begin
               next_chan_data        <= out_buf;
               next_chan_volume_load <= 1'b1;
            end
         end
         // 010 drives upper byte, 011 lower; zero while attach-volume or attach-period is set
         if (attach_volume || attach_period)
            dac_sample <= 8'h00;
         else if (penhi)
            dac_sample <= out_buf[15:8];
         else
            dac_sample <= out_buf[7:0];
      end
   end

   // AXI4-Lite slave; control, period, length and data registers
   always @(posedge clk or negedge rst_s2) begin
      if (!rst_s2) begin
         s_axi_awready    <= 1'b0;
         s_axi_wready     <= 1'b0;
         s_axi_bvalid     <= 1'b0;
         s_axi_bresp      <= 2'h0;
         s_axi_arready    <= 1'b0;
         s_axi_rvalid     <= 1'b0;
         s_axi_rresp      <= 2'h0;
         s_axi_rdata      <= 32'h00000000;
         aw_got           <= 1'b0;
         w_got            <= 1'b0;
         aw_addr          <= 4'h0;
         w_data           <= 32'h00000000;
         w_strb           <= 4'h0;
         chan_dma_enable  <= 1'b0;
         attach_volume    <= 1'b0;
         attach_period    <= 1'b0;
         period_value_reg <= `PERIOD_RESET;
         length_backup    <= `LENGTH_RESET;
         volume           <= `VOLUME_MAX;
      end else begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_arready <= 1'b0;
         if (s_axi_awvalid && !aw_got && !s_axi_awready) begin
            s_axi_awready <= 1'b1;
            aw_got        <= 1'b1;
            aw_addr       <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_got && !s_axi_wready) begin
            s_axi_wready <= 1'b1;
            w_got        <= 1'b1;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_got       <= 1'b0;
            w_got        <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= 2'h0;
            case (aw_addr)
               `REG_CTRL: if (w_strb[0]) begin
                  chan_dma_enable <= w_data[`CTRL_DMA_EN];
                  attach_volume   <= w_data[`CTRL_ATT_VOL];
                  attach_period   <= w_data[`CTRL_ATT_PER];
               end
               `REG_PERIOD: begin
                  if (w_strb[0]) period_value_reg[7:0]  <= w_data[7:0];
                  if (w_strb[1]) period_value_reg[15:8] <= w_data[15:8];
               end
               `REG_LENGTH: begin
                  if (w_strb[0]) length_backup[7:0]  <= w_data[7:0];
                  if (w_strb[1]) length_backup[15:8] <= w_data[15:8];
               end
               `REG_DATA: ;
               default: s_axi_bresp <= 2'h2;
            endcase
         end else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         // the previous channel may steer period or volume
         if (prev_period_load)
            period_value_reg <= prev_data;
         // volume tops out at 40 hex
         if (prev_volume_load)
            volume <= (prev_data[6:0] > `VOLUME_MAX) ? `VOLUME_MAX
                                                     : prev_data[6:0];
         if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready)
            s_axi_arready <= 1'b1;
         // Answer only after the address handshake edge
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= 2'h0;
            case (s_axi_araddr)
               `REG_CTRL: s_axi_rdata <= {20'h00000, chan_irq_pending,
                  state_bits, 5'h00, attach_period, attach_volume,
                  chan_dma_enable};
               `REG_PERIOD: s_axi_rdata <= {16'h0000, period_cnt};
               `REG_LENGTH: s_axi_rdata <= {16'h0000, length_cnt};
               `REG_DATA:   s_axi_rdata <= {16'h0000, out_buf};
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= 2'h2;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// file: design/audio_chan_map.vh
// Purpose: constants for the audio channel sequencer
// Assumes: plain Verilog-2005, included by bare name
// Notes:   state codes, AXI4-Lite map, field positions, reset values
`ifndef AUDIO_CHAN_MAP_VH
`define AUDIO_CHAN_MAP_VH

// Sequencer state codes (three bits)
`define ST_IDLE       3'h0
`define ST_DMA_FIRST  3'h1
`define ST_HIGH       3'h2
`define ST_LOW        3'h3
`define ST_UNUSED4    3'h4
`define ST_DMA_DROP   3'h5
`define ST_UNUSED6    3'h6
`define ST_UNUSED7    3'h7

// Register byte offsets
`define REG_CTRL      4'h0
`define REG_PERIOD    4'h4
`define REG_LENGTH    4'h8
`define REG_DATA      4'hc

// Control register fields
`define CTRL_DMA_EN   0
`define CTRL_ATT_VOL  1
`define CTRL_ATT_PER  2
`define CTRL_IRQ_CLR  3

// Status fields, read at the control offset
`define STAT_STATE_LO 8
`define STAT_PEND     11

// Reset and limit values
`define PERIOD_RESET  16'h0001
`define LENGTH_RESET  16'h0001
`define VOLUME_MAX    7'h40

// System clock in kHz (3.58 MHz) and fabric clock in kHz (200 MHz)
`define SYS_CLK_KHZ   3580
`define FAB_CLK_KHZ   200000
`define SYS_DIV       (`FAB_CLK_KHZ / `SYS_CLK_KHZ)

`endif

// file: test/audio_dma_model.sv
// Purpose: behavioural DMA controller facing one audio channel
// Assumes: one request taken per line slot, answered after LAT clocks
// Notes:   data lines toggle while no word is offered
`default_nettype none
module audio_dma_model #(
   parameter int LINE = 32,
   parameter int LAT  = 8
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // Requests from the channel
   input  wire logic        word_fetch_request,
   input  wire logic        pointer_restart_request,
   // Returned words
   output var  logic        dma_word_valid,
   output var  logic [15:0] dma_word
);
   timeunit 1ns;
   timeprecision 1ps;
   int         slot;
   int         wait_n;
   logic       busy;
   logic [7:0] ptr;

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         slot <= 0;
         wait_n <= 0;
         busy <= 1'b0;
         ptr <= 8'h00;
         dma_word_valid <= 1'b0;
         dma_word <= 16'h0000;
      end else begin
         slot <= (slot == LINE - 1) ? 0 : slot + 1;
         dma_word_valid <= 1'b0;
         // Never a stale word on released lines
         dma_word <= ~dma_word;
         if (!busy && slot == 0 && word_fetch_request) begin
            busy <= 1'b1;
            wait_n <= LAT;
            if (pointer_restart_request)
               ptr <= 8'h00;
         end else if (busy && wait_n > 1) begin
            wait_n <= wait_n - 1;
         end else if (busy) begin
            busy <= 1'b0;
            dma_word_valid <= 1'b1;
            dma_word <= {8'ha0 + ptr, 8'h50 + ptr};
            ptr <= ptr + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// file: test/audio_channel_state_machine_checker.sv
// Purpose: port checks for the audio channel sequencer
// Assumes: DIV equals the bound instance's divider
// Notes:   tick-timed moves get a bound of two ticks plus two clocks
`include "audio_chan_map.vh"
`default_nettype none
module audio_channel_state_machine_checker #(
   parameter DIV = 4
) (
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst_b,
   // DMA side
   input wire logic       word_fetch_request,
   input wire logic       pointer_restart_request,
   input wire logic       dma_word_valid,
   // Interrupt and converter side
   input wire logic       chan_irq_request,
   input wire logic [6:0] volume,
   input wire logic [2:0] state_bits
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TICK = 2 * DIV + 2;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   property p_unused;
      state_bits inside {`ST_UNUSED4, `ST_UNUSED6, `ST_UNUSED7}
         |-> ##[1:TICK] state_bits == `ST_IDLE;
   endproperty
   a_unused: assert property (p_unused) else $error("unused state held");
   property p_reset;
      $rose(rst_b) |-> state_bits == `ST_IDLE && volume == `VOLUME_MAX
         && !word_fetch_request && !chan_irq_request;
   endproperty
   a_reset: assert property (p_reset) else $error("not idle at reset");
   property p_request;
      state_bits == `ST_DMA_FIRST |-> ##[0:TICK] word_fetch_request;
   endproperty
   a_request: assert property (p_request) else $error("no word request");
   property p_first;
      state_bits == `ST_DMA_FIRST && dma_word_valid
         |-> ##[1:TICK] state_bits == `ST_DMA_DROP;
   endproperty
   a_first: assert property (p_first) else $error("first word kept");
   property p_next;
      state_bits == `ST_DMA_DROP && dma_word_valid
         |-> ##[1:TICK] state_bits == `ST_HIGH;
   endproperty
   a_next: assert property (p_next) else $error("loop not entered");
   property p_restart;
      pointer_restart_request |-> word_fetch_request;
   endproperty
   a_restart: assert property (p_restart) else $error("lone restart");
   property p_volume;
      volume <= `VOLUME_MAX;
   endproperty
   a_volume: assert property (p_volume) else $error("volume too high");
   property p_irq;
      chan_irq_request |=> !chan_irq_request;
   endproperty
   a_irq: assert property (p_irq) else $error("irq held too long");
endmodule

bind audio_channel_state_machine audio_channel_state_machine_checker #(
   .DIV(DIV)
) u_audio_channel_state_machine_checker (
   .clk(clk), .rst_b(rst_b), .word_fetch_request(word_fetch_request),
   .pointer_restart_request(pointer_restart_request),
   .dma_word_valid(dma_word_valid), .chan_irq_request(chan_irq_request),
   .volume(volume), .state_bits(state_bits)
);
`default_nettype wire

// file: test/audio_channel_state_machine_tb.sv
// Purpose: self-checking bench for the audio channel sequencer
// Assumes: DIV of 4, so one sequencer tick is four clocks
// Notes:   pending interrupt is modelled here; software clear optional
`include "audio_chan_map.vh"
`default_nettype none
module audio_channel_state_machine_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int          DIV = 4;
   localparam logic [31:0] PER = 32'h3;
   logic        clk = 1'b0, rst_b = 1'b0;
   logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
   logic [31:0] wdata = 32'h0, rd;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, pend = 1'b0, auto_clr = 1'b1;
   logic [15:0] prev_data = 16'h0000;
   logic        prev_vload = 1'b0, prev_pload = 1'b0;
   wire  logic  awready, wready, bvalid, arready, rvalid, wfr, prr;
   wire  logic  dvalid, irq, vload, pload;
   wire  logic [1:0]  bresp, rresp;
   wire  logic [31:0] rdata;
   wire  logic [15:0] dword, ndata;
   wire  logic [7:0]  dac;
   wire  logic [6:0]  volume;
   wire  logic [2:0]  st;
   int   errors = 0, n_compared = 0, n_irq = 0, n_vol = 0, n_per = 0;
   int   n_rst = 0, vis [8] = '{default: 0};
   // Mode rows: control bits, volume load, period load, irq seen
   logic [5:0] rows [4] = '{6'b001_001, 6'b011_101, 6'b101_010, 6'b111_111};

   audio_channel_state_machine #(
      .DIV(DIV)
   ) u_audio_channel_state_machine (
      .clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .word_fetch_request(wfr), .pointer_restart_request(prr),
      .dma_word_valid(dvalid), .dma_word(dword),
      .chan_irq_pending(pend), .chan_irq_request(irq), .dac_sample(dac),
      .prev_data(prev_data), .prev_volume_load(prev_vload),
      .prev_period_load(prev_pload),
      .volume(volume), .next_chan_data(ndata),
      .next_chan_volume_load(vload), .next_chan_period_load(pload),
      .state_bits(st)
   );
   audio_dma_model u_audio_dma_model (
      .clk(clk), .rst_b(rst_b), .word_fetch_request(wfr),
      .pointer_restart_request(prr), .dma_word_valid(dvalid),
      .dma_word(dword)
   );

   always #2.5 clk = ~clk;

   // pending set by request, cleared by software
   always @(posedge clk) begin
      if (irq)
         pend <= 1'b1;
      else if (auto_clr)
         pend <= 1'b0;
      n_irq <= n_irq + int'(irq);
      n_vol <= n_vol + int'(vload);
      n_per <= n_per + int'(pload);
      n_rst <= n_rst + int'(prr);
      vis[st] <= vis[st] + 1;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic axw(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      fork
         begin do @(posedge clk); while (!awready); awvalid <= 1'b0; end
         begin do @(posedge clk); while (!wready); wvalid <= 1'b0; end
      join
      while (!bvalid) @(posedge clk);
      bready <= 1'b0;
   endtask

   task automatic axr(input logic [3:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      while (!rvalid) @(posedge clk);
      rd = rdata;
      rready <= 1'b0;
   endtask

   // Counts clocks until the state shows, then compares it
   task automatic ws(input logic [2:0] s, output int t);
      t = 0;
      while (st !== s && t < 3000) begin
         @(posedge clk);
         t++;
      end
      chk({29'h0, st}, {29'h0, s});
   endtask

   task automatic complete_run;
      if (errors == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      int t;
      int snap [6];
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      chk({25'h0, volume}, {25'h0, `VOLUME_MAX});
      chk({27'h0, st, irq, wfr}, 32'h0);
      axr(`REG_PERIOD);
      chk({16'h0, rd[15:0]}, {16'h0, `PERIOD_RESET});
      axr(4'h2);
      chk({30'h0, rresp}, 32'h2);
      axw(`REG_PERIOD, PER);
      axw(`REG_LENGTH, 32'h2);
      // Length reads the live counter, not the backup
      axr(`REG_LENGTH);
      chk({16'h0, rd[15:0]}, {16'h0, `LENGTH_RESET});
      // Processor word; the first word is cleared in time
      axw(`REG_DATA, 32'hc3a5);
      ws(`ST_HIGH, t);
      #1;
      chk({24'h0, dac}, 32'hc3);
      ws(`ST_LOW, t);
      #1;
      chk({24'h0, dac}, 32'ha5);
      ws(`ST_HIGH, t);
      // Pending left set from here, so the next word ends the loop
      auto_clr <= 1'b0;
      #1;
      chk(t, PER * DIV);
      chk({24'h0, dac}, 32'hc3);
      ws(`ST_LOW, t);
      // One request as the loop starts, one per word done
      chk(n_irq, 32'h2);
      ws(`ST_IDLE, t);
      auto_clr <= 1'b1;
      foreach (rows[i]) begin
         axw(`REG_CTRL, {29'h0, rows[i][5:3]});
         snap = '{n_vol, n_per, n_irq, vis[1], vis[5], n_rst};
         repeat (1500) @(posedge clk);
         chk({31'h0, n_vol > snap[0]}, {31'h0, rows[i][2]});
         chk({31'h0, n_per > snap[1]}, {31'h0, rows[i][1]});
         chk({31'h0, n_irq > snap[2]}, {31'h0, rows[i][0]});
         chk({30'h0, vis[1] > snap[3], vis[5] > snap[4]}, 32'h3);
         chk({31'h0, n_rst > snap[5]}, 32'h1);
         // Without DMA only an uncleared interrupt ends the loop
         auto_clr <= 1'b0;
         axw(`REG_CTRL, 32'h0);
         ws(`ST_IDLE, t);
         auto_clr <= 1'b1;
      end
      // Volume from the previous channel, then clamped
      prev_data  <= 16'h0021;
      prev_vload <= 1'b1;
      @(posedge clk);
      prev_vload <= 1'b0;
      @(posedge clk);
      chk({25'h0, volume}, 32'h21);
      prev_data  <= 16'h007f;
      prev_vload <= 1'b1;
      @(posedge clk);
      prev_vload <= 1'b0;
      @(posedge clk);
      chk({25'h0, volume}, {25'h0, `VOLUME_MAX});
      // Reset while the channel is streaming
      axw(`REG_CTRL, 32'h1);
      repeat (300) @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      chk({27'h0, st, irq, wfr}, 32'h0);
      chk({25'h0, volume}, {25'h0, `VOLUME_MAX});
      complete_run;
   end

   initial begin
      repeat (40000) @(posedge clk);
      errors++;
      complete_run;
   end
endmodule
`default_nettype wire
